// ---- verilog/cvr_params.svh ----
`ifndef CVR_PARAMS_SVH
`define CVR_PARAMS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define CVR_ADDR_W 8
`define CVR_REF_OFS 8'h00
`define CVR_CTL_OFS 8'h01
`define CVR_REF_RST 8'h32
`define CVR_CTL_RST 8'h84

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CVR_CTL_EN_BIT 7
`define CVR_CTL_MODE_BIT 6
`define CVR_CTL_RSVD_BIT 5
`define CVR_CTL_STEP_HI 4
`define CVR_CTL_STEP_LO 3
`define CVR_CTL_DIV_HI 2
`define CVR_CTL_DIV_LO 0
`define CVR_CTL_WR_MASK 8'hDF

// ----------------------------------------------------------------
// Reference decode
// ----------------------------------------------------------------
`define CVR_LOW_MIN 7'h32
`define CVR_LOW_MAX 7'h78
`define CVR_LOW_STEP_UV 10000

// ----------------------------------------------------------------
// Step timing, times in ns, counts in clk cycles
// ----------------------------------------------------------------
`define CVR_CLK_PERIOD_NS 100
`define CVR_STEP0_NS 20000
`define CVR_STEP1_NS 41670
`define CVR_STEP2_NS 83330
`define CVR_STEP3_NS 166670
`define CVR_STEP_CYC(ns) ((ns) / `CVR_CLK_PERIOD_NS)

`endif

// ---- verilog/cvr_pkg.sv ----
package cvr_pkg;

  typedef logic [7:0] cvr_byte_t;

  typedef struct packed {
    logic [7:0] ref_code;
    logic [7:0] ctl;
    logic [7:0] rd_data;
    logic rd_valid;
    logic conv_en;
    logic low_mode;
    logic [1:0] step_sel;
    logic [4:0] fb_denom;
    logic [23:0] ref_uv;
    logic ref_valid;
    logic [10:0] step_cnt;
    logic step_tick;
  } cvr_state_t;

endpackage

// ---- verilog/cvr_ref_decode.sv ----
`include "cvr_params.svh"

module cvr_ref_decode
  import cvr_pkg::*;
#(
  parameter int NORMAL_STEP_UV = 10000
)
(
  input wire logic [7:0] ref_code,
  input wire logic low_mode,
  output logic [23:0] ref_uv,
  output logic ref_valid
);

  logic [6:0] low_code;

  assign low_code = ref_code[6:0];

  always_comb
  begin
    if (low_mode)
    begin
      // Top bit dropped, so 0xB2 decodes like 0x32
      ref_valid = (low_code >= `CVR_LOW_MIN) && (low_code <= `CVR_LOW_MAX);
      if (ref_valid)
      begin
        ref_uv = 24'(32'(low_code) * `CVR_LOW_STEP_UV);
      end
      else
      begin
        ref_uv = 24'h000000;
      end
    end
    else
    begin
      ref_valid = 1'b1;
      ref_uv = 24'(32'(ref_code) * NORMAL_STEP_UV);
    end
  end

endmodule // cvr_ref_decode

// ---- verilog/cvr_regs.sv ----
// Functional notes
// - Low mode codes 32h-78h give code times 10mV
// - Low mode codes outside range are reserved
// - Low mode ignores reference code top bit
// - Enable bit turns converter off or on
// - Mode bit selects normal or low input
// - Step field sets soft-start step duration
// - Divider field selects feedback ratio 1 to 1/30
// - Reserved bits always read back zero
`include "cvr_params.svh"

module cvr_regs
  import cvr_pkg::*;
#(
  parameter int NORMAL_STEP_UV = 10000
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic conv_en,
  output logic low_mode,
  output logic [1:0] step_sel,
  output logic step_tick,
  output logic [4:0] fb_denom,
  output logic [23:0] ref_uv,
  output logic ref_valid
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic addr_is_ref(input logic [7:0] addr);
    addr_is_ref = (addr == `CVR_REF_OFS);
  endfunction

  function automatic logic addr_is_ctl(input logic [7:0] addr);
    addr_is_ctl = (addr == `CVR_CTL_OFS);
  endfunction

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  // Reserved bit forced low both on write and on read
  function automatic logic [7:0] ctl_clean(input logic [7:0] raw);
    ctl_clean = raw & `CVR_CTL_WR_MASK;
  endfunction

  function automatic logic ctl_enable(input logic [7:0] ctl);
    ctl_enable = ctl[`CVR_CTL_EN_BIT];
  endfunction

  function automatic logic ctl_low_mode(input logic [7:0] ctl);
    ctl_low_mode = ctl[`CVR_CTL_MODE_BIT];
  endfunction

  function automatic logic [1:0] ctl_step(input logic [7:0] ctl);
    ctl_step = ctl[`CVR_CTL_STEP_HI:`CVR_CTL_STEP_LO];
  endfunction

  function automatic logic [2:0] ctl_div(input logic [7:0] ctl);
    ctl_div = ctl[`CVR_CTL_DIV_HI:`CVR_CTL_DIV_LO];
  endfunction

  // ----------------------------------------------------------------
  // Step and divider tables
  // ----------------------------------------------------------------
  // Counts round down, so a step may run up to one clock short
  function automatic logic [10:0] step_limit(input logic [1:0] sel);
    case (sel)
      2'h0: step_limit = 11'(`CVR_STEP_CYC(`CVR_STEP0_NS));
      2'h1: step_limit = 11'(`CVR_STEP_CYC(`CVR_STEP1_NS));
      2'h2: step_limit = 11'(`CVR_STEP_CYC(`CVR_STEP2_NS));
      default: step_limit = 11'(`CVR_STEP_CYC(`CVR_STEP3_NS));
    endcase
  endfunction

  function automatic logic [4:0] div_denom(input logic [2:0] code);
    case (code)
      3'h0: div_denom = 5'h01;
      3'h1: div_denom = 5'h02;
      3'h2: div_denom = 5'h03;
      3'h3: div_denom = 5'h05;
      3'h4: div_denom = 5'h0A;
      3'h5: div_denom = 5'h14;
      3'h6: div_denom = 5'h1E;
      // Code 7 undefined, zero flags it
      default: div_denom = 5'h00;
    endcase
  endfunction

  // Unmapped offsets read zero instead of aliasing a register
  function automatic logic [7:0] read_mux(input logic [7:0] addr, input logic [7:0] ref_code,
    input logic [7:0] ctl);
    if (addr_is_ref(addr))
    begin
      read_mux = ref_code;
    end
    else if (addr_is_ctl(addr))
    begin
      read_mux = ctl_clean(ctl);
    end
    else
    begin
      read_mux = 8'h00;
    end
  endfunction

  // Derived fields start at zero and decode one edge after release
  function automatic cvr_state_t reset_state();
    cvr_state_t s;
    s = '0;
    s.ref_code = `CVR_REF_RST;
    s.ctl = `CVR_CTL_RST;
    reset_state = s;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cvr_state_t s_q;
  cvr_state_t s_d;
  logic [23:0] dec_uv;
  logic dec_valid;

  cvr_ref_decode #(
    .NORMAL_STEP_UV(NORMAL_STEP_UV)
  ) u_dec (
    .ref_code(s_q.ref_code),
    .low_mode(ctl_low_mode(s_q.ctl)),
    .ref_uv(dec_uv),
    .ref_valid(dec_valid)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    if (reg_wr)
    begin
      if (addr_is_ref(reg_addr))
      begin
        s_d.ref_code = reg_wdata;
      end
      else if (addr_is_ctl(reg_addr))
      begin
        s_d.ctl = ctl_clean(reg_wdata);
      end
    end
    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    // A read in the cycle of a write returns the old value
    s_d.rd_valid = reg_rd;
    if (reg_rd)
    begin
      s_d.rd_data = read_mux(reg_addr, s_q.ref_code, s_q.ctl);
    end
    // ----------------------------------------------------------------
    // Derived outputs
    // ----------------------------------------------------------------
    // One edge behind the register so all outputs move together
    s_d.conv_en = ctl_enable(s_q.ctl);
    s_d.low_mode = ctl_low_mode(s_q.ctl);
    s_d.step_sel = ctl_step(s_q.ctl);
    s_d.fb_denom = div_denom(ctl_div(s_q.ctl));
    s_d.ref_uv = dec_uv;
    s_d.ref_valid = dec_valid;
    // ----------------------------------------------------------------
    // Step pacing
    // ----------------------------------------------------------------
    s_d.step_tick = 1'b0;
    // Only while converter is on; off restarts the step
    if (!ctl_enable(s_q.ctl))
    begin
      s_d.step_cnt = 11'h000;
    end
    else if (s_q.step_cnt >= step_limit(ctl_step(s_q.ctl)) - 11'h001)
    begin
      // Compare with >= so a shorter step chosen mid-count ends at once
      s_d.step_cnt = 11'h000;
      s_d.step_tick = 1'b1;
    end
    else
    begin
      s_d.step_cnt = s_q.step_cnt + 11'h001;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_q <= reset_state();
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = s_q.rd_data;
  assign reg_rvalid = s_q.rd_valid;
  assign conv_en = s_q.conv_en;
  assign low_mode = s_q.low_mode;
  assign step_sel = s_q.step_sel;
  assign step_tick = s_q.step_tick;
  assign fb_denom = s_q.fb_denom;
  assign ref_uv = s_q.ref_uv;
  assign ref_valid = s_q.ref_valid;

endmodule // cvr_regs

// ---- testbench/cvr_regs_assertions.sv ----
module cvr_regs_chk
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic conv_en,
  input wire logic low_mode,
  input wire logic [1:0] step_sel,
  input wire logic step_tick,
  input wire logic [4:0] fb_denom,
  input wire logic [23:0] ref_uv,
  input wire logic ref_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence ctl_wr_s;
    reg_wr && reg_addr == 8'h01;
  endsequence
  // Derived outputs lag the register by one edge
  a_en_apply: assert property (ctl_wr_s |-> ##2 conv_en == $past(reg_wdata[7], 2))
    else $error("enable not applied");
  a_mode_apply: assert property (ctl_wr_s |-> ##2 low_mode == $past(reg_wdata[6], 2))
    else $error("mode not applied");
  a_step_apply: assert property (ctl_wr_s |-> ##2 step_sel == $past(reg_wdata[4:3], 2))
    else $error("step code not applied");
  a_div_tenth: assert property ((ctl_wr_s ##0 reg_wdata[2:0] == 3'h4) |-> ##2 fb_denom == 5'hA)
    else $error("divider code 4 wrong");
  a_rsvd_zero: assert property (reg_rvalid && $past(reg_addr) == 8'h01 |-> !reg_rdata[5])
    else $error("reserved bit reads one");
  a_low_range: assert property (low_mode && ref_valid |-> ref_uv inside {[24'h7A120:24'h124F80]})
    else $error("low mode reference out of range");
  a_bad_zero: assert property (!ref_valid |-> ref_uv == 24'h0)
    else $error("invalid code gives reference");
  a_tick_off: assert property (!conv_en [*2] |-> !step_tick)
    else $error("step tick while disabled");
endmodule // cvr_regs_chk

bind cvr_regs cvr_regs_chk u_chk (.clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
  .reg_rvalid, .conv_en, .low_mode, .step_sel, .step_tick, .fb_denom, .ref_uv, .ref_valid);

// ---- testbench/cvr_host.sv ----
module cvr_host
(
  input wire logic clk,
  output logic [7:0] reg_addr = 8'h00,
  output logic reg_wr = 1'b0,
  output logic [7:0] reg_wdata = 8'h00,
  output logic reg_rd = 1'b0,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~v; // Stale data must never look valid
    repeat (2) @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic ok);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
    ok = reg_rvalid;
  endtask
endmodule // cvr_host

// ---- testbench/cvr_regs_tb.sv ----
module cvr_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cvr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, reg_rvalid, conv_en, low_mode, step_tick, ref_valid, ok;
  logic [1:0] step_sel;
  logic [4:0] fb_denom;
  logic [23:0] ref_uv;
  cvr_byte_t d;
  cvr_byte_t lo[4] = '{8'hB2, 8'h78, 8'h79, 8'h31};
  logic [23:0] lo_uv[4] = '{24'h7A120, 24'h124F80, 24'h0, 24'h0};
  logic [4:0] dv[7] = '{5'h1, 5'h2, 5'h3, 5'h5, 5'hA, 5'h14, 5'h1E};
  logic [11:0] st[4] = '{12'hC8, 12'h1A0, 12'h341, 12'h682};
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  initial forever #50 clk = ~clk;
  cvr_regs uut (.clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .reg_rvalid, .conv_en, .low_mode, .step_sel, .step_tick, .fb_denom, .ref_uv, .ref_valid);
  cvr_host host (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Counts cycles up to the next step tick, bounded
  task automatic gap(input int lim);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (step_tick !== 1'b1 && n < lim);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_of_test;
    end
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    host.rd(8'h00, d, ok);
    chk({ok, d}, 9'h132);
    chk(ref_uv, 24'h7A120);
    host.rd(8'h01, d, ok);
    chk({conv_en, fb_denom, d}, 14'h2A84);
    host.wr(8'h01, 8'hFF);
    host.rd(8'h01, d, ok);
    chk({low_mode, fb_denom, d}, 14'h20DF);
    // Top bit set on the first code: must be ignored in low mode
    foreach (lo[i])
    begin
      host.wr(8'h00, lo[i]);
      chk({ref_valid, ref_uv}, {lo_uv[i] != 24'h0, lo_uv[i]});
    end
    host.wr(8'h01, 8'h80);
    host.wr(8'h00, 8'hB2);
    chk(ref_uv, 24'h1B2920);
    foreach (dv[i])
    begin
      host.wr(8'h01, 8'(8'h80 + i));
      chk(fb_denom, dv[i]);
    end
    // First gap only syncs, the second is a full step
    foreach (st[i])
    begin
      host.wr(8'h01, 8'(8'h80 + i * 8));
      gap(2000);
      gap(2000);
      chk(n, st[i]);
      chk(step_sel, i);
    end
    host.wr(8'h01, 8'h00);
    gap(300);
    chk(n, 300);
    chk({conv_en, step_tick}, 2'h0);
    host.rd(8'h05, d, ok);
    chk({ok, d}, 9'h100);
    // Mid-run reset must bring back the power-on settings
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({conv_en, ref_valid, step_tick, reg_rvalid}, 4'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    host.rd(8'h00, d, ok);
    chk({ok, d}, 9'h132);
    host.rd(8'h01, d, ok);
    chk({ok, d}, 9'h184);
    chk({conv_en, fb_denom, ref_uv}, {1'b1, 5'h0A, 24'h7A120});
    end_of_test;
  end
endmodule // cvr_regs_tb
